// *** hdl/pmu_pkg.sv ***
/*
 * Shared constants and types of the pipelined multiply unit:
 * opfields, result kinds, stage numbers, flag layout, register map.
 * Assumes a single core clock domain.
 */
`default_nettype none

package pmu_pkg;
    // opfields seen by the multiply unit
    localparam logic [4:0] OP_ILO_REG   = 5'h04;
    localparam logic [4:0] OP_ILO_CST   = 5'h06;
    localparam logic [4:0] OP_IFULL_REG = 5'h08;
    localparam logic [4:0] OP_IFULL_CST = 5'h0c;
    localparam logic [4:0] OP_SP        = 5'h1c;
    localparam logic [4:0] OP_DP        = 5'h0e;

    typedef enum logic [1:0] {
        K_SP    = 2'h0,
        K_DP    = 2'h1,
        K_ILO   = 2'h2,
        K_IFULL = 2'h3
    } pmu_kind_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_E2   = 4'h2,
        ST_E3   = 4'h4,
        ST_E4   = 4'h8
    } pmu_state_t;

    // pipeline stages, issue cycle is stage 1
    localparam int SP_WRITE_STAGE = 4;
    localparam int LONG_LO_STAGE  = 9;
    localparam int RESULT_STAGE   = 5;

    localparam int FLAG_W      = 4;
    localparam int FLG_INVALID = 0;
    localparam int FLG_INEXACT = 1;
    localparam int FLG_DEN1    = 2;
    localparam int FLG_DEN2    = 3;

    localparam logic [10:0] EXP_MAX_DP = 11'h7ff;
    localparam logic [10:0] EXP_MAX_SP = 11'h0ff;
    localparam logic [13:0] BIAS_DP    = 14'h03ff;
    localparam logic [13:0] BIAS_SP    = 14'h007f;

    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_MASK   = 8'h04;
    localparam logic [7:0] ADDR_STATE  = 8'h08;
    localparam logic [3:0] STATUS_RST  = 4'h0;
    localparam logic [3:0] MASK_RST    = 4'h0;
endpackage

`default_nettype wire

// *** hdl/pmu_delay_line.sv ***
/*
 * Fixed-depth register delay line carrying result records down the pipe.
 * Assumes one clock; reset clears every stage, so valid bits start low.
 */
`default_nettype none

module pmu_delay_line #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] dIn,
    output logic      [WIDTH-1:0] dOut
);
    logic [WIDTH-1:0] stage_r [DEPTH];

    for (genvar i = 0; i < DEPTH; i++) begin : g_stage
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                stage_r[i] <= '0;
            end else if (i == 0) begin
                stage_r[i] <= dIn;
            end else begin
                stage_r[i] <= stage_r[(i == 0) ? 0 : i - 1];
            end
        end
    end

    assign dOut = stage_r[DEPTH-1];
endmodule

`default_nettype wire

// *** hdl/pmu_multiply_unit.sv ***
/*
 * Pipelined multiply unit: sp and dp float multiply, integer low-word
 * and full-pair multiply, sticky float flags with interrupt, APB slave.
 * Assumes dispatch drives operand words in the stages they are read,
 * and never schedules two low-port writes into one cycle.
 */
// Added by the designer: the APB interface to the registers and the register offsets.
`default_nettype none

module pmu_multiply_unit (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        issueValid,
    input  wire logic [4:0]  issueOp,
    input  wire logic        issueCond,
    input  wire logic [4:0]  issueConst,
    input  wire logic [4:0]  issueDst,
    input  wire logic [31:0] opSrc1,
    input  wire logic [31:0] opSrc2,
    output logic             issueReady,
    output logic             wrLoValid,
    output logic      [4:0]  wrLoAddr,
    output logic      [31:0] wrLoData,
    output logic             wrHiValid,
    output logic      [4:0]  wrHiAddr,
    output logic      [31:0] wrHiData,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq
);
    localparam int LW = 75;
    localparam int SW = 42;

    // returns {legal, kind}
    function automatic logic [2:0] decodeOp(input logic [4:0] op);
        case (op)
            pmu_pkg::OP_ILO_REG,
            pmu_pkg::OP_ILO_CST:   decodeOp = {1'b1, pmu_pkg::K_ILO};
            pmu_pkg::OP_IFULL_REG,
            pmu_pkg::OP_IFULL_CST: decodeOp = {1'b1, pmu_pkg::K_IFULL};
            pmu_pkg::OP_SP:        decodeOp = {1'b1, pmu_pkg::K_SP};
            pmu_pkg::OP_DP:        decodeOp = {1'b1, pmu_pkg::K_DP};
            default:               decodeOp = 3'h0;
        endcase
    endfunction

    // returns {flags, result}; sp operands and result in the low word
    function automatic logic [67:0] fpMul(
        input logic        isDp,
        input logic [63:0] a,
        input logic [63:0] b
    );
        logic [10:0]  ea, eb, emax;
        logic [51:0]  ma, mb;
        logic         sr, nA, nB, sgA, sgB, iA, iB, zA, zB, dA, dB, g, st;
        logic [105:0] p;
        logic [52:0]  keep;
        logic [53:0]  r;
        logic [13:0]  ex;
        logic [63:0]  res;
        logic [3:0]   fl;
        begin
            sr = isDp ? (a[63] ^ b[63]) : (a[31] ^ b[31]);
            ea = isDp ? a[62:52] : {3'h0, a[30:23]};
            eb = isDp ? b[62:52] : {3'h0, b[30:23]};
            ma = isDp ? a[51:0] : {a[22:0], 29'h0};
            mb = isDp ? b[51:0] : {b[22:0], 29'h0};
            emax = isDp ? pmu_pkg::EXP_MAX_DP : pmu_pkg::EXP_MAX_SP;
            nA = (ea == emax) && (ma != 52'h0);
            nB = (eb == emax) && (mb != 52'h0);
            sgA = nA && !ma[51];
            sgB = nB && !mb[51];
            iA = (ea == emax) && (ma == 52'h0);
            iB = (eb == emax) && (mb == 52'h0);
            zA = (ea == 11'h0) && (ma == 52'h0);
            zB = (eb == 11'h0) && (mb == 52'h0);
            dA = (ea == 11'h0) && (ma != 52'h0);
            dB = (eb == 11'h0) && (mb != 52'h0);
            fl = 4'h0;
            fl[pmu_pkg::FLG_DEN1] = dA;
            fl[pmu_pkg::FLG_DEN2] = dB;
            p = {1'b1, ma} * {1'b1, mb};
            ex = 14'(ea) + 14'(eb) - (isDp ? pmu_pkg::BIAS_DP : pmu_pkg::BIAS_SP)
                + {13'h0, p[105]};
            if (!p[105]) begin
                p = p << 1;
            end
            keep = isDp ? p[105:53] : {29'h0, p[105:82]};
            g = isDp ? p[52] : p[81];
            st = isDp ? |p[51:0] : |p[80:0];
            // round to nearest even
            r = {1'b0, keep} + {53'h0, g & (st | keep[0])};
            if (isDp ? r[53] : r[24]) begin
                ex = ex + 14'h1;
                r = r >> 1;
            end
            // default: signed default NaN
            res = isDp ? {sr, {63{1'b1}}} : {32'h0, sr, {31{1'b1}}};
            if (nA || nB) begin
                fl[pmu_pkg::FLG_INVALID] = sgA || sgB;
            end else if ((iA && (zB || dB)) || (iB && (zA || dA))) begin
                fl[pmu_pkg::FLG_INVALID] = 1'b1;
            end else if (iA || iB) begin
                res = isDp ? {sr, pmu_pkg::EXP_MAX_DP, 52'h0}
                           : {32'h0, sr, pmu_pkg::EXP_MAX_SP[7:0], 23'h0};
            end else if (zA || dA || zB || dB) begin
                res = isDp ? {sr, 63'h0} : {32'h0, sr, 31'h0};
                fl[pmu_pkg::FLG_INEXACT] = (dA && !zB) || (dB && !zA);
            end else if ($signed(ex) >= $signed({3'h0, emax})) begin
                res = isDp ? {sr, pmu_pkg::EXP_MAX_DP, 52'h0}
                           : {32'h0, sr, pmu_pkg::EXP_MAX_SP[7:0], 23'h0};
                fl[pmu_pkg::FLG_INEXACT] = 1'b1;
            end else if ($signed(ex) <= $signed(14'h0)) begin
                res = isDp ? {sr, 63'h0} : {32'h0, sr, 31'h0};
                fl[pmu_pkg::FLG_INEXACT] = 1'b1;
            end else begin
                res = isDp ? {sr, ex[10:0], r[51:0]} : {32'h0, sr, ex[7:0], r[22:0]};
                fl[pmu_pkg::FLG_INEXACT] = g | st;
            end
            fpMul = {fl, res};
        end
    endfunction

    pmu_pkg::pmu_state_t state_r, stateNxt;
    pmu_pkg::pmu_kind_t  kind, kind_r;
    logic [2:0]  dec;
    logic        acc, accLong, isCst;
    logic [31:0] src1Int;
    logic [63:0] intProd, prod_r;
    logic [4:0]  dst_r;
    logic [31:0] lo1_r, lo2_r;
    logic [67:0] spRes, dpRes;
    logic [LW-1:0] longIn, longOut;
    logic [SW-1:0] spIn, spOut;
    logic        issueReady_r;
    logic        wrLoValid_r, wrHiValid_r, hiPend_r;
    logic [4:0]  wrLoAddr_r, wrHiAddr_r, hiAddr_r;
    logic [31:0] wrLoData_r, wrHiData_r, hiData_r;
    logic [3:0]  status_r, mask_r, evFlags, clr, status;
    logic        irq_r, pready_r, pslverr_r, apbWr;
    logic [31:0] prdata_r;
    logic        lv, sv;

    assign dec = decodeOp(issueOp);
    assign kind = pmu_pkg::pmu_kind_t'(dec[1:0]);
    // false predicate: nothing enters the pipe
    assign acc = issueValid && issueReady_r && issueCond && dec[2];
    assign accLong = acc && (kind != pmu_pkg::K_SP);
    assign isCst = (issueOp == pmu_pkg::OP_ILO_CST) || (issueOp == pmu_pkg::OP_IFULL_CST);
    assign src1Int = isCst ? {{27{issueConst[4]}}, issueConst} : opSrc1;
    assign intProd = {{32{src1Int[31]}}, src1Int} * {{32{opSrc2[31]}}, opSrc2};

    // long ops hold the unit for stages 1 to 4
    always_comb begin
        stateNxt = state_r;
        unique case (state_r)
            pmu_pkg::ST_IDLE: begin
                if (accLong) begin
                    stateNxt = pmu_pkg::ST_E2;
                end
            end
            pmu_pkg::ST_E2: stateNxt = pmu_pkg::ST_E3;
            pmu_pkg::ST_E3: stateNxt = pmu_pkg::ST_E4;
            pmu_pkg::ST_E4: stateNxt = pmu_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= pmu_pkg::ST_IDLE;
            issueReady_r <= 1'b1;
        end else begin
            state_r <= stateNxt;
            issueReady_r <= (stateNxt == pmu_pkg::ST_IDLE);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            kind_r <= pmu_pkg::K_ILO;
            dst_r <= 5'h0;
            prod_r <= 64'h0;
            lo1_r <= 32'h0;
            lo2_r <= 32'h0;
        end else begin
            if (accLong) begin
                kind_r <= kind;
                dst_r <= issueDst;
                prod_r <= intProd;
            end
            // dp low words arrive in stage 3, high words in stage 4
            if (state_r == pmu_pkg::ST_E3) begin
                lo1_r <= opSrc1;
                lo2_r <= opSrc2;
            end
        end
    end

    assign dpRes = fpMul(1'b1, {opSrc1, lo1_r}, {opSrc2, lo2_r});
    assign spRes = fpMul(1'b0, {32'h0, opSrc1}, {32'h0, opSrc2});

    always_comb begin
        longIn = '0;
        longIn[74] = (state_r == pmu_pkg::ST_E4);
        longIn[73] = (kind_r != pmu_pkg::K_ILO);
        longIn[72:68] = dst_r;
        if (kind_r == pmu_pkg::K_DP) begin
            longIn[67:0] = dpRes;
        end else if (kind_r == pmu_pkg::K_ILO) begin
            longIn[31:0] = prod_r[31:0];
        end else begin
            longIn[63:0] = prod_r;
        end
    end

    assign spIn = {acc && (kind == pmu_pkg::K_SP), issueDst, spRes[67:64], spRes[31:0]};

    pmu_delay_line #(
        .WIDTH(LW),
        .DEPTH(pmu_pkg::LONG_LO_STAGE - pmu_pkg::RESULT_STAGE)
    ) u_long_pipe (
        .clk (clk),
        .rst (rst),
        .dIn (longIn),
        .dOut(longOut)
    );

    pmu_delay_line #(
        .WIDTH(SW),
        .DEPTH(pmu_pkg::SP_WRITE_STAGE - 2)
    ) u_sp_pipe (
        .clk (clk),
        .rst (rst),
        .dIn (spIn),
        .dOut(spOut)
    );

    assign lv = longOut[74];
    assign sv = spOut[41];

    // write ports: long low word stage 9, sp word stage 4, high word stage 10
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wrLoValid_r <= 1'b0;
            wrLoAddr_r <= 5'h0;
            wrLoData_r <= 32'h0;
            hiPend_r <= 1'b0;
            hiAddr_r <= 5'h0;
            hiData_r <= 32'h0;
            wrHiValid_r <= 1'b0;
            wrHiAddr_r <= 5'h0;
            wrHiData_r <= 32'h0;
        end else begin
            wrLoValid_r <= lv || sv;
            wrLoAddr_r <= lv ? longOut[72:68] : spOut[40:36];
            wrLoData_r <= lv ? longOut[31:0] : spOut[31:0];
            hiPend_r <= lv && longOut[73];
            hiAddr_r <= longOut[72:68] | 5'h01;
            hiData_r <= longOut[63:32];
            // low word leads high by one cycle for early dp consumers
            wrHiValid_r <= hiPend_r;
            wrHiAddr_r <= hiAddr_r;
            wrHiData_r <= hiData_r;
        end
    end

    assign evFlags = lv ? longOut[67:64] : (sv ? spOut[35:32] : 4'h0);
    assign apbWr = psel && penable && pready_r && pwrite && !pslverr_r;
    assign clr = (apbWr && (paddr == pmu_pkg::ADDR_STATUS)) ? pwdata[3:0] : 4'h0;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            status_r <= pmu_pkg::STATUS_RST;
            mask_r <= pmu_pkg::MASK_RST;
            irq_r <= 1'b0;
        end else begin
            // a flag raised in the clearing cycle survives
            status_r <= (status_r & ~clr) | evFlags;
            if (apbWr && (paddr == pmu_pkg::ADDR_MASK)) begin
                mask_r <= pwdata[3:0];
            end
            irq_r <= |(status_r & mask_r);
        end
    end

    // zero-wait slave: pready high in the first access cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0;
        end else begin
            pready_r <= psel && !penable;
            pslverr_r <= psel && !penable && (paddr != pmu_pkg::ADDR_STATUS)
                && (paddr != pmu_pkg::ADDR_MASK) && (paddr != pmu_pkg::ADDR_STATE);
            if (psel && !penable) begin
                case (paddr)
                    pmu_pkg::ADDR_STATUS: prdata_r <= {28'h0, status_r};
                    pmu_pkg::ADDR_MASK:   prdata_r <= {28'h0, mask_r};
                    pmu_pkg::ADDR_STATE:  prdata_r <= {27'h0, state_r, issueReady_r};
                    default:              prdata_r <= 32'h0;
                endcase
            end
        end
    end

    assign issueReady = issueReady_r;
    assign wrLoValid = wrLoValid_r;
    assign wrLoAddr = wrLoAddr_r;
    assign wrLoData = wrLoData_r;
    assign wrHiValid = wrHiValid_r;
    assign wrHiAddr = wrHiAddr_r;
    assign wrHiData = wrHiData_r;
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign irq = irq_r;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_sp_write_stage: assert property (
        acc && (kind == pmu_pkg::K_SP) && !accLong |-> ##3 wrLoValid
            && (wrLoAddr == $past(issueDst, 3)))
        else $error("sp result not written in stage 4");

    a_long_busy: assert property (
        accLong |=> !issueReady [*3] ##1 issueReady)
        else $error("long op did not hold the unit four stages");

    a_dp_pair: assert property (
        acc && (kind == pmu_pkg::K_DP) |-> ##8 wrLoValid
            ##1 (wrHiValid && (wrHiAddr == ($past(wrLoAddr) | 5'h01))))
        else $error("dp pair not written in stages 9 and 10");

    a_ilo_low_only: assert property (
        accLong && (issueOp == pmu_pkg::OP_ILO_REG) |-> ##8 (wrLoValid
            && (wrLoData == $past(intProd[31:0], 8))) ##1 !wrHiValid)
        else $error("low-word multiply result wrong or high word written");

    a_full_high: assert property (
        accLong && (kind == pmu_pkg::K_IFULL) |-> ##9 wrHiValid
            && (wrHiData == $past(intProd[63:32], 9)))
        else $error("full multiply high word wrong");

    a_cst_decode: assert property (
        acc && (issueOp == pmu_pkg::OP_ILO_CST) |-> ##8 wrLoValid
            && (wrLoData == 32'($signed($past(issueConst, 8)) * $signed($past(opSrc2, 8)))))
        else $error("short constant form gave wrong product");

    a_sp_snan: assert property (
        acc && (kind == pmu_pkg::K_SP) && (opSrc1[30:23] == 8'hff) && !opSrc1[22]
            && (opSrc1[21:0] != 22'h0) |-> ##3 status[pmu_pkg::FLG_INVALID]
            && (wrLoData[30:0] == 31'h7fffffff))
        else $error("signalling NaN not flagged invalid");

    a_zero_inf: assert property (
        acc && (kind == pmu_pkg::K_SP) && (opSrc1[30:0] == 31'h0)
            && (opSrc2[30:0] == 31'h7f800000) |-> ##3 wrLoValid
            && (wrLoData == {$past(opSrc1[31], 3) ^ $past(opSrc2[31], 3), 31'h7fffffff}))
        else $error("zero times infinity not default NaN");

    assign status = status_r;
    a_flag_sticky: assert property (
        &(~$past(status) | status | $past(clr)))
        else $error("status flag lost without a clear");
endmodule

`default_nettype wire

// *** verification/pmu_regfile_model.sv ***
/*
 * Register file model standing on the destination side of the multiply unit.
 * Assumes the unit's two write ports and the single core clock.
 */
`default_nettype none

module pmu_regfile_model (
    input  wire logic        clk,
    input  wire logic        wrLoValid,
    input  wire logic [4:0]  wrLoAddr,
    input  wire logic [31:0] wrLoData,
    input  wire logic        wrHiValid,
    input  wire logic [4:0]  wrHiAddr,
    input  wire logic [31:0] wrHiData
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [31:0] regs [32];

    // low word lands a cycle ahead of the high word, so a consumer may read it early
    always @(posedge clk) begin
        if (wrLoValid === 1'b1) regs[wrLoAddr] <= wrLoData;
        if (wrHiValid === 1'b1) regs[wrHiAddr] <= wrHiData;
    end
endmodule

`default_nettype wire

// *** verification/pmu_multiply_unit_tb.sv ***
/*
 * Self-checking bench of the multiply unit: float, integer, predicate,
 * sticky flags, interrupt and apb cases. Assumes the unit and the regfile model.
 */
`default_nettype none
`define CHK(a, e) begin numChecks++; if ((a) !== (e)) begin miscompares++; \
    $display("unexpected at %0t: got %h want %h", $time, (a), (e)); end end

module pmu_multiply_unit_tb;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [4:0]  op;
        logic [4:0]  cst;
        logic [63:0] a, b, r;
        int          tl, th;
        logic [3:0]  st;
    } pmu_case_t;

    logic        clk, rst, issueValid, issueCond, issueReady, wrLoValid, wrHiValid;
    logic [4:0]  issueOp, issueConst, issueDst, wrLoAddr, wrHiAddr;
    logic [31:0] opSrc1, opSrc2, wrLoData, wrHiData, pwdata, prdata;
    logic        psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0]  paddr;
    int          miscompares = 0;
    int          numChecks = 0;
    pmu_case_t   cases [$] = '{
        '{5'h1c, 5'h0, 64'h40000000, 64'h40400000, 64'h40c00000, 3, -1, 4'h0},
        '{5'h1c, 5'h0, 64'h3fc00000, 64'h3f800001, 64'h3fc00002, 3, -1, 4'h2},
        '{5'h1c, 5'h0, 64'h7f800001, 64'h40000000, 64'h7fffffff, 3, -1, 4'h1},
        '{5'h1c, 5'h0, 64'hffc00000, 64'h40000000, 64'hffffffff, 3, -1, 4'h0},
        '{5'h1c, 5'h0, 64'h7f800000, 64'hff800000, 64'hff800000, 3, -1, 4'h0},
        '{5'h1c, 5'h0, 64'h7f800000, 64'h40000000, 64'h7f800000, 3, -1, 4'h0},
        '{5'h1c, 5'h0, 64'h80000000, 64'h7f800000, 64'hffffffff, 3, -1, 4'h1},
        '{5'h1c, 5'h0, 64'h80000000, 64'h40000000, 64'h80000000, 3, -1, 4'h0},
        '{5'h1c, 5'h0, 64'h00000001, 64'h40000000, 64'h00000000, 3, -1, 4'h6},
        '{5'h1c, 5'h0, 64'h40000000, 64'h80000001, 64'h80000000, 3, -1, 4'ha},
        '{5'h1c, 5'h0, 64'h7f800000, 64'h00000001, 64'h7fffffff, 3, -1, 4'h9},
        '{5'h0e, 5'h0, 64'h4008000000000000, 64'hc004000000000000,
          64'hc01e000000000000, 8, 9, 4'h0},
        '{5'h0e, 5'h0, 64'h7ff0000000000001, 64'h4008000000000000,
          64'h7fffffffffffffff, 8, 9, 4'h1},
        '{5'h04, 5'h0, 64'hfffffffe, 64'h3, 64'hfffffffa, 8, -1, 4'h0},
        '{5'h06, 5'h1d, 64'h12345678, 64'h7, 64'hffffffeb, 8, -1, 4'h0},
        '{5'h08, 5'h0, 64'h10000, 64'h10000, 64'h100000000, 8, 9, 4'h0},
        '{5'h0c, 5'h1d, 64'h0, 64'h2, 64'hfffffffffffffffa, 8, 9, 4'h0}
    };

    pmu_multiply_unit uut (.clk, .rst, .issueValid, .issueOp, .issueCond, .issueConst,
        .issueDst, .opSrc1, .opSrc2, .issueReady, .wrLoValid, .wrLoAddr, .wrLoData,
        .wrHiValid, .wrHiAddr, .wrHiData, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .irq);

    pmu_regfile_model rf (.clk, .wrLoValid, .wrLoAddr, .wrLoData, .wrHiValid, .wrHiAddr,
        .wrHiData);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", numChecks, miscompares);
        if (miscompares == 0 && numChecks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // issues one op and records the cycles of its writes; dp words follow in c2 and c3
    task automatic run(input pmu_case_t c, input logic cnd, output int tl, output int th,
                       output logic [3:0] rdy);
        tl = -1;
        th = -1;
        rdy = 4'h0;
        @(posedge clk);
        issueValid <= 1'b1;
        issueOp    <= c.op;
        issueCond  <= cnd;
        issueConst <= c.cst;
        issueDst   <= 5'h04;
        opSrc1     <= c.a[31:0];
        opSrc2     <= c.b[31:0];
        for (int k = 0; k < 12; k++) begin
            @(posedge clk);
            if (k >= 1 && k <= 4) rdy[k-1] = issueReady;
            if (wrLoValid === 1'b1 && wrLoAddr === 5'h04) tl = k;
            if (wrHiValid === 1'b1 && wrHiAddr === 5'h05) th = k;
            issueValid <= 1'b0;
            opSrc1 <= (k == 1) ? c.a[31:0] : (k == 2) ? c.a[63:32] : ~opSrc1;
            opSrc2 <= (k == 1) ? c.b[31:0] : (k == 2) ? c.b[63:32] : ~opSrc2;
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
        int n;
        n = 0;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= ad;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            miscompares++;
            print_verdict();
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic expect_reg(input logic [7:0] ad, input logic [31:0] e);
        logic [31:0] d;
        logic        er;
        apb(1'b0, ad, 32'h0, d, er);
        `CHK({er, d}, {1'b0, e})
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        print_verdict();
    end

    initial begin
        int          tl, th;
        logic [3:0]  rdy;
        logic [31:0] d;
        logic        er;
        rst = 1'b1;
        {issueValid, issueCond, psel, penable, pwrite} = 5'h0;
        {issueOp, issueConst, issueDst, paddr} = 23'h0;
        {opSrc1, opSrc2, pwdata} = 96'h0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        expect_reg(8'h00, 32'h0);
        expect_reg(8'h04, 32'h0);
        expect_reg(8'h08, 32'h3);
        foreach (cases[i]) begin
            run(cases[i], 1'b1, tl, th, rdy);
            `CHK(tl, cases[i].tl)
            `CHK(th, cases[i].th)
            `CHK(rdy, (cases[i].op === 5'h1c) ? 4'hf : 4'h8)
            `CHK(rf.regs[4], cases[i].r[31:0])
            if (cases[i].th >= 0) `CHK(rf.regs[5], cases[i].r[63:32])
            expect_reg(8'h00, {28'h0, cases[i].st});
            apb(1'b1, 8'h00, 32'hf, d, er);
        end
        run(cases[2], 1'b0, tl, th, rdy);
        `CHK(tl, -1)
        expect_reg(8'h00, 32'h0);
        run(cases[2], 1'b1, tl, th, rdy);
        run(cases[1], 1'b1, tl, th, rdy);
        expect_reg(8'h00, 32'h3);
        `CHK(irq, 1'b0)
        apb(1'b1, 8'h04, 32'h2, d, er);
        expect_reg(8'h04, 32'h2);
        `CHK(irq, 1'b1)
        apb(1'b1, 8'h00, 32'h2, d, er);
        expect_reg(8'h00, 32'h1);
        `CHK(irq, 1'b0)
        apb(1'b0, 8'h0c, 32'h0, d, er);
        `CHK({er, d}, 33'h100000000)
        print_verdict();
    end
endmodule

`default_nettype wire
